// [inc/pscr_defines.svh]
// Purpose: Register addresses, bit positions and reset values of the status bank
// Assumes: Five-bit management register addresses, 16-bit data
// Notes: Definitions only
`ifndef PSCR_DEFINES_SVH
`define PSCR_DEFINES_SVH
`define PSCR_ADDR_GEN_STATUS 5'h18
`define PSCR_ADDR_EXT_STATUS 5'h19
`define PSCR_ADDR_FAULT_CNT 5'h1a
`define PSCR_GS_INT 15
`define PSCR_GS_PLL 14
`define PSCR_GS_LWAKE 13
`define PSCR_GS_BWAKE 12
`define PSCR_GS_TWAKE 11
`define PSCR_GS_EN 10
`define PSCR_GS_RST 9
`define PSCR_GS_CNT_HI 7
`define PSCR_GS_CNT_LO 3
`define PSCR_ES_UV3V3 14
`define PSCR_ES_UVD1V8 13
`define PSCR_ES_UVA1V8 12
`define PSCR_ES_UVIO 11
`define PSCR_ES_THIGH 10
`define PSCR_ES_TWARN 9
`define PSCR_ES_SHORT 8
`define PSCR_ES_OPEN 7
`define PSCR_ES_POL 6
`define PSCR_ES_ILV 5
`define PSCR_LINK_CNT_RST 5'h00
`define PSCR_LINK_CNT_MAX 5'h1f
`define PSCR_FCNT_RST 8'h00
`define PSCR_FCNT_MAX 8'hff
`define PSCR_DATA_ZERO 16'h0000
// Synchroniser idle levels: enable pin and receiver OK inputs idle high
`define PSCR_SYNC_RST 22'h002003
`endif

// [inc/pscr_pkg.sv]
// Purpose: Types shared by the status bank
// Assumes: None
// Notes: Register select encoding
package pscr_pkg;
    typedef enum logic [1:0] {
        PSCR_SEL_NONE = 2'b00,
        PSCR_SEL_GEN = 2'b01,
        PSCR_SEL_EXT = 2'b10,
        PSCR_SEL_CNT = 2'b11
    } pscr_sel_type;
endpackage : pscr_pkg

// [hdl/pscr_sat_counter.sv]
// Purpose: Eight-bit saturating event counter cleared by a read
// Assumes: Same clock as the register bank
// Notes: Clear and increment together load one so no event is lost
`timescale 1ns/10ps
`include "pscr_defines.svh"
module pscr_sat_counter (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic inc_i,
    input wire logic clr_i,
    output logic [7:0] count_o
);
    logic [7:0] count_q;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            count_q <= `PSCR_FCNT_RST;
        end else if (clr_i) begin
            count_q <= inc_i ? 8'h01 : `PSCR_FCNT_RST;
        end else if (inc_i && count_q != `PSCR_FCNT_MAX) begin
            count_q <= count_q + 8'h01;
        end
    end
    assign count_o = count_q;
endmodule : pscr_sat_counter

// [hdl/pscr_status_regs.sv]
// Purpose: Read-only status and receiver fault counter registers of the PHY
// Assumes: Register reads arrive as a one-cycle strobe with address, same clock
// Notes: Outside event levels pass two flip-flops before use
// Operation
// - PLL lock reads 0 if unstable since last read, 1 only while locked.
// - Local wake-up latches high until the general status read.
// - Bus wake-up latches high until the general status read.
// - In sleep request, line data or transmit enable latches traffic wake.
// - Enable pin low latches history flag until read; 0 if high since last read.
// - Hardware reset sets history flag, cleared by reading.
// - Five-bit link drop count since last read, restarts after read.
// - Link drop count returns to default when link control disabled.
// - Four supply undervoltage flags latch high until read.
// - High temperature and warning flags latch high until read.
// - Cable short flag latches until read.
// - Cable open flag latches until read.
// - Short, open and polarity keep values with link control disabled.
// - Polarity inversion is reported live, not latched.
// - Interleave order reported live, retained across link control disable.
// - Local receiver fault counter in upper byte counts not-OK cycles.
// - Remote receiver fault counter in lower byte counts not-OK cycles.
// - Fault counters saturate at their maximum value.
// - Reading fault counter register clears both counters.
// - External status bits 4 to 0 reserved, read only.
`timescale 1ns/10ps
`include "pscr_defines.svh"
module pscr_status_regs (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic rd_i,
    input wire logic [4:0] addr_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    input wire logic irq_pending_i,
    input wire logic link_control_i,
    input wire logic sleep_request_i,
    input wire logic pll_locked_i,
    input wire logic local_wake_i,
    input wire logic bus_wake_i,
    input wire logic rx_dv_i,
    input wire logic tx_en_i,
    input wire logic enable_pin_i,
    input wire logic link_fail_i,
    input wire logic [3:0] undervolt_i,
    input wire logic temp_high_i,
    input wire logic temp_warn_i,
    input wire logic short_i,
    input wire logic open_i,
    input wire logic polarity_i,
    input wire logic interleave_i,
    input wire logic local_rx_ok_i,
    input wire logic remote_rx_ok_i
);
    localparam int NIN = 22;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] s1_q;
    logic [NIN-1:0] s2_q;
    logic s_irq;
    logic s_link;
    logic s_sleep;
    logic s_pll;
    logic s_lwake;
    logic s_bwake;
    logic s_dv;
    logic s_txen;
    logic s_en;
    logic s_lfail;
    logic [3:0] s_uv;
    logic s_thigh;
    logic s_twarn;
    logic s_short;
    logic s_open;
    logic s_pol;
    logic s_ilv;
    logic s_lok;
    logic s_rok;
    logic lfail_prev_q;
    logic lfail_rise;
    pscr_pkg::pscr_sel_type sel;
    logic rd_gen;
    logic rd_ext;
    logic rd_cnt;
    logic pll_q;
    logic lwake_q;
    logic bwake_q;
    logic twake_q;
    logic en_q;
    logic rst_q;
    logic [4:0] link_cnt_q;
    logic [3:0] uv_q;
    logic thigh_q;
    logic twarn_q;
    logic short_q;
    logic open_q;
    logic [7:0] loc_cnt;
    logic [7:0] rem_cnt;
    logic [15:0] gen_word;
    logic [15:0] ext_word;
    logic [15:0] rdata_d;

    assign raw = {irq_pending_i, link_control_i, sleep_request_i, pll_locked_i,
                  local_wake_i, bus_wake_i, rx_dv_i, tx_en_i, enable_pin_i, link_fail_i,
                  undervolt_i, temp_high_i, temp_warn_i, short_i, open_i, polarity_i,
                  interleave_i, local_rx_ok_i, remote_rx_ok_i};

    // Two-stage synchroniser; reset to idle levels so no false event follows
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s1_q <= `PSCR_SYNC_RST;
            s2_q <= `PSCR_SYNC_RST;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    assign {s_irq, s_link, s_sleep, s_pll, s_lwake, s_bwake, s_dv, s_txen, s_en, s_lfail,
            s_uv, s_thigh, s_twarn, s_short, s_open, s_pol, s_ilv, s_lok, s_rok} = s2_q;

    // Address decode
    always_comb begin
        if (addr_i == `PSCR_ADDR_GEN_STATUS) begin
            sel = pscr_pkg::PSCR_SEL_GEN;
        end else if (addr_i == `PSCR_ADDR_EXT_STATUS) begin
            sel = pscr_pkg::PSCR_SEL_EXT;
        end else if (addr_i == `PSCR_ADDR_FAULT_CNT) begin
            sel = pscr_pkg::PSCR_SEL_CNT;
        end else begin
            sel = pscr_pkg::PSCR_SEL_NONE;
        end
    end

    assign rd_gen = rd_i && (sel == pscr_pkg::PSCR_SEL_GEN);
    assign rd_ext = rd_i && (sel == pscr_pkg::PSCR_SEL_EXT);
    assign rd_cnt = rd_i && (sel == pscr_pkg::PSCR_SEL_CNT);

    // PLL lock latches low; a read reloads the live state
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pll_q <= 1'b0;
        end else if (!s_pll) begin
            pll_q <= 1'b0;
        end else if (rd_gen) begin
            pll_q <= 1'b1;
        end
    end

    // Local wake-up latch; set wins over the read clear
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            lwake_q <= 1'b0;
        end else begin
            lwake_q <= s_lwake | (lwake_q & ~rd_gen);
        end
    end

    // Bus wake-up latch
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            bwake_q <= 1'b0;
        end else begin
            bwake_q <= s_bwake | (bwake_q & ~rd_gen);
        end
    end

    // Traffic wake latch, armed only in sleep request
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            twake_q <= 1'b0;
        end else begin
            twake_q <= (s_sleep & (s_dv | s_txen)) | (twake_q & ~rd_gen);
        end
    end

    // Enable pin history latch
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            en_q <= 1'b0;
        end else begin
            en_q <= ~s_en | (en_q & ~rd_gen);
        end
    end

    // Reset history: set by the hardware reset, cleared by a read
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rst_q <= 1'b1;
        end else if (rd_gen) begin
            rst_q <= 1'b0;
        end
    end

    // Link drop counter, counting rising edges of link failure
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            lfail_prev_q <= 1'b0;
        end else begin
            lfail_prev_q <= s_lfail;
        end
    end

    assign lfail_rise = s_lfail && !lfail_prev_q;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || !s_link) begin
            link_cnt_q <= `PSCR_LINK_CNT_RST;
        end else if (rd_gen) begin
            link_cnt_q <= lfail_rise ? 5'h01 : `PSCR_LINK_CNT_RST;
        end else if (lfail_rise && link_cnt_q != `PSCR_LINK_CNT_MAX) begin
            link_cnt_q <= link_cnt_q + 5'h01;
        end
    end

    // Supply undervoltage latches, untouched by link control
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            uv_q <= 4'h0;
        end else begin
            uv_q <= s_uv | (uv_q & {4{~rd_ext}});
        end
    end

    // Temperature latches
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            thigh_q <= 1'b0;
            twarn_q <= 1'b0;
        end else begin
            thigh_q <= s_thigh | (thigh_q & ~rd_ext);
            twarn_q <= s_twarn | (twarn_q & ~rd_ext);
        end
    end

    // Cable short latch, kept while link control is off
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            short_q <= 1'b0;
        end else begin
            short_q <= s_short | (short_q & ~rd_ext);
        end
    end

    // Cable open latch, kept while link control is off
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            open_q <= 1'b0;
        end else begin
            open_q <= s_open | (open_q & ~rd_ext);
        end
    end

    pscr_sat_counter u_loc_cnt (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .inc_i(~s_lok),
        .clr_i(rd_cnt),
        .count_o(loc_cnt)
    );

    pscr_sat_counter u_rem_cnt (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .inc_i(~s_rok),
        .clr_i(rd_cnt),
        .count_o(rem_cnt)
    );

    // Read words; reserved bits stay zero
    always_comb begin
        gen_word = `PSCR_DATA_ZERO;
        gen_word[`PSCR_GS_INT] = s_irq;
        gen_word[`PSCR_GS_PLL] = pll_q & s_pll;
        gen_word[`PSCR_GS_LWAKE] = lwake_q;
        gen_word[`PSCR_GS_BWAKE] = bwake_q;
        gen_word[`PSCR_GS_TWAKE] = twake_q;
        gen_word[`PSCR_GS_EN] = en_q;
        gen_word[`PSCR_GS_RST] = rst_q;
        gen_word[`PSCR_GS_CNT_HI:`PSCR_GS_CNT_LO] = link_cnt_q;
        ext_word = `PSCR_DATA_ZERO;
        ext_word[`PSCR_ES_UV3V3] = uv_q[3];
        ext_word[`PSCR_ES_UVD1V8] = uv_q[2];
        ext_word[`PSCR_ES_UVA1V8] = uv_q[1];
        ext_word[`PSCR_ES_UVIO] = uv_q[0];
        ext_word[`PSCR_ES_THIGH] = thigh_q;
        ext_word[`PSCR_ES_TWARN] = twarn_q;
        ext_word[`PSCR_ES_SHORT] = short_q;
        ext_word[`PSCR_ES_OPEN] = open_q;
        ext_word[`PSCR_ES_POL] = s_pol;
        ext_word[`PSCR_ES_ILV] = s_ilv;
        if (rd_gen) begin
            rdata_d = gen_word;
        end else if (rd_ext) begin
            rdata_d = ext_word;
        end else if (rd_cnt) begin
            rdata_d = {loc_cnt, rem_cnt};
        end else begin
            rdata_d = `PSCR_DATA_ZERO;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= `PSCR_DATA_ZERO;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_i;
            if (rd_i) begin
                rdata_o <= rdata_d;
            end
        end
    end
endmodule : pscr_status_regs

// [test/pscr_status_regs_assertions.sv]
// Purpose: Port-level checks of the status register bank
// Assumes: Inputs pass two sync flops before use
// Notes: Bound to pscr_status_regs
`timescale 1ns/10ps
module pscr_status_regs_assertions (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic rd_i,
    input wire logic [4:0] addr_i,
    input wire logic [15:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic irq_pending_i,
    input wire logic link_control_i,
    input wire logic pll_locked_i,
    input wire logic polarity_i,
    input wire logic interleave_i
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic gen_rd;
    logic ext_rd;
    assign gen_rd = rd_i && addr_i == 5'h18;
    assign ext_rd = rd_i && addr_i == 5'h19;
    a_read_answer: assert property (rd_i |=> rvalid_o) else $error("read not answered");
    a_answer_cause: assert property (rvalid_o |-> $past(rd_i)) else $error("stray rvalid");
    a_data_holds: assert property (!rd_i |=> $stable(rdata_o)) else $error("rdata moved");
    a_unmapped_zero: assert property (rd_i && (addr_i < 5'h18 || addr_i > 5'h1a) |=>
        rdata_o == 16'h0000) else $error("unmapped not zero");
    a_gen_reserved: assert property (gen_rd |=>
        rdata_o[8] == 1'b0 && rdata_o[2:0] == 3'h0) else $error("general reserved set");
    a_ext_reserved: assert property (ext_rd |=>
        rdata_o[15] == 1'b0 && rdata_o[4:0] == 5'h00) else $error("external reserved set");
    a_int_summary: assert property (irq_pending_i[*3] ##0 gen_rd |=> rdata_o[15])
        else $error("summary bit low");
    a_pll_unlocked: assert property ((!pll_locked_i)[*3] ##0 gen_rd |=> !rdata_o[14])
        else $error("lock shown while unlocked");
    a_count_forced: assert property ((!link_control_i)[*4] ##0 gen_rd |=>
        rdata_o[7:3] == 5'h00) else $error("drop count not forced");
    a_polarity_live: assert property (polarity_i[*3] ##0 ext_rd |=> rdata_o[6])
        else $error("polarity not shown");
    a_interleave_live: assert property (interleave_i[*3] ##0 ext_rd |=> rdata_o[5])
        else $error("interleave not shown");
    c_gen_read: cover property (gen_rd);
    c_ext_read: cover property (ext_rd);
    c_cnt_read: cover property (rd_i && addr_i == 5'h1a);
endmodule : pscr_status_regs_assertions
bind pscr_status_regs pscr_status_regs_assertions u_chk (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .rd_i(rd_i), .addr_i(addr_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .irq_pending_i(irq_pending_i), .link_control_i(link_control_i),
    .pll_locked_i(pll_locked_i), .polarity_i(polarity_i), .interleave_i(interleave_i));

// [test/pscr_status_regs_tb.sv]
// Purpose: Self-checking bench of the status register bank
// Assumes: Inputs driven 1 ns after the rising edge
// Notes: Events settle through two sync flops before a read
`timescale 1ns/10ps
module pscr_status_regs_tb;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic rd_i = 1'b0;
    logic [4:0] addr_i = 5'h00;
    logic [15:0] rdata_o;
    logic rvalid_o;
    logic irq = 1'b0, lc = 1'b1, slp = 1'b0, pll = 1'b1, pol = 1'b0, ilv = 1'b0;
    logic lok = 1'b1, rok = 1'b1;
    logic [13:0] ev = 14'h0000;
    logic [15:0] et [14] = '{16'h2000, 16'h1000, 16'h0400, 16'h0800, 16'h0800, 16'h0008,
        16'h0800, 16'h1000, 16'h2000, 16'h4000, 16'h0400, 16'h0200, 16'h0100, 16'h0080};
    int err_count = 0;
    int checks = 0;
    pscr_status_regs u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .rd_i(rd_i),
        .addr_i(addr_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .irq_pending_i(irq),
        .link_control_i(lc), .sleep_request_i(slp), .pll_locked_i(pll),
        .local_wake_i(ev[0]), .bus_wake_i(ev[1]), .enable_pin_i(~ev[2]), .rx_dv_i(ev[3]),
        .tx_en_i(ev[4]), .link_fail_i(ev[5]), .undervolt_i(ev[9:6]), .temp_high_i(ev[10]),
        .temp_warn_i(ev[11]), .short_i(ev[12]), .open_i(ev[13]), .polarity_i(pol),
        .interleave_i(ilv), .local_rx_ok_i(lok), .remote_rx_ok_i(rok));
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic print_verdict();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    task automatic rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge ref_clk_i);
        #1 rd_i = 1'b1;
        addr_i = a;
        @(posedge ref_clk_i);
        #1 rd_i = 1'b0;
        checks++;
        if ({rvalid_o, rdata_o & m} !== {1'b1, e}) begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, {rvalid_o, rdata_o & m}, {1'b1, e});
        end
    endtask : rd
    task automatic wt();
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask : wt
    task automatic pulse(input int i);
        @(posedge ref_clk_i);
        #1 ev[i] = 1'b1;
        @(posedge ref_clk_i);
        #1 ev[i] = 1'b0;
        wt();
    endtask : pulse
    task automatic t_reset();
        wt();
        rd(5'h18, 16'hffff, 16'h0200);
        rd(5'h18, 16'hffff, 16'h4000);
        rd(5'h19, 16'hffff, 16'h0000);
        rd(5'h1a, 16'hffff, 16'h0000);
        rd(5'h1a, 16'hffff, 16'h0000);
        rd(5'h00, 16'hffff, 16'h0000);
        rd(5'h1b, 16'hffff, 16'h0000);
    endtask : t_reset
    task automatic t_events();
        slp = 1'b1;
        for (int i = 0; i < 6; i++) begin
            pulse(i);
            rd(5'h18, 16'hffff, 16'h4000 | et[i]);
            rd(5'h18, 16'hffff, 16'h4000);
        end
        for (int i = 6; i < 14; i++) begin
            pulse(i);
            rd(5'h19, 16'hffff, et[i]);
            rd(5'h19, 16'hffff, 16'h0000);
        end
        slp = 1'b0;
        pulse(3);
        rd(5'h18, 16'hffff, 16'h4000);
    endtask : t_events
    task automatic t_link();
        repeat (3) pulse(5);
        rd(5'h18, 16'hffff, 16'h4018);
        repeat (2) pulse(5);
        pulse(12);
        lc = 1'b0;
        pol = 1'b1;
        ilv = 1'b1;
        wt();
        rd(5'h18, 16'hffff, 16'h4000);
        rd(5'h19, 16'hffff, 16'h0160);
        rd(5'h19, 16'hffff, 16'h0060);
        lc = 1'b1;
        pol = 1'b0;
        ilv = 1'b0;
        wt();
        rd(5'h19, 16'hffff, 16'h0000);
    endtask : t_link
    task automatic t_pll_irq();
        pll = 1'b0;
        wt();
        rd(5'h18, 16'hffff, 16'h0000);
        pll = 1'b1;
        wt();
        rd(5'h18, 16'hffff, 16'h0000);
        rd(5'h18, 16'hffff, 16'h4000);
        @(posedge ref_clk_i);
        #1 pll = 1'b0;
        @(posedge ref_clk_i);
        #1 pll = 1'b1;
        wt();
        rd(5'h18, 16'hffff, 16'h0000);
        rd(5'h18, 16'hffff, 16'h4000);
        irq = 1'b1;
        wt();
        rd(5'h18, 16'hffff, 16'hc000);
        irq = 1'b0;
        wt();
        rd(5'h18, 16'hffff, 16'h4000);
    endtask : t_pll_irq
    task automatic t_faults();
        @(posedge ref_clk_i);
        #1 lok = 1'b0;
        rok = 1'b0;
        repeat (5) @(posedge ref_clk_i);
        #1 lok = 1'b1;
        repeat (295) @(posedge ref_clk_i);
        #1 rok = 1'b1;
        wt();
        rd(5'h1a, 16'hffff, 16'h05ff);
        rd(5'h1a, 16'hffff, 16'h0000);
    endtask : t_faults
    initial begin
        #100us;
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        #1 sys_rst_i = 1'b0;
        t_reset();
        t_events();
        t_link();
        t_pll_irq();
        t_faults();
        print_verdict();
    end
endmodule : pscr_status_regs_tb
